// file: iopw_pkg.sv
// Shared constants and types of the paged memory window.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package iopw_pkg;

    localparam int          DATA_W       = 8;
    localparam int          HIGH_W       = 7;
    localparam int          LOW_W        = 8;
    localparam int          POS_W        = 7;
    localparam int          ARR_AW       = 18;
    localparam int          BOARD_W      = 3;

    // Port offsets within the group of four
    localparam logic [1:0]  OFS_DATA     = 2'h0;
    localparam logic [1:0]  OFS_HIGH     = 2'h1;
    localparam logic [1:0]  OFS_LOW      = 2'h2;
    localparam logic [1:0]  OFS_POS      = 2'h3;

    // Field positions in the high address register
    localparam int          HI_PROT      = 6;
    localparam int          HI_BOARD_MSB = 5;
    localparam int          HI_BOARD_LSB = 3;
    localparam int          HI_BANK_MSB  = 2;
    localparam int          HI_PAGE_TOP  = 0;

    localparam logic [HIGH_W-1:0] HIGH_RST = 7'h00;
    localparam logic [LOW_W-1:0]  LOW_RST  = 8'h00;
    localparam logic [POS_W-1:0]  POS_RST  = 7'h00;
    localparam logic [POS_W-1:0]  POS_STEP = 7'h01;

    // Array write pacing: one stored byte every second clock
    localparam logic [1:0]  PACE_STEP    = 2'h1;
    localparam logic [1:0]  PACE_LAST    = 2'h1;

    typedef enum logic [1:0] {
        IOPW_IDLE    = 2'b00,
        IOPW_RD_WAIT = 2'b01,
        IOPW_RD_MEM  = 2'b10
    } iopw_phase_t;

    typedef struct packed {
        logic [ARR_AW-1:0] addr;
        logic [DATA_W-1:0] data;
    } iopw_wr_t;

    typedef struct packed {
        iopw_phase_t       phase;
        logic [HIGH_W-1:0] high;
        logic [LOW_W-1:0]  low;
        logic [POS_W-1:0]  pos;
        logic [ARR_AW-1:0] rd_addr;
        logic [DATA_W-1:0] rdata;
        logic              rdata_oe;
        logic              rd_valid;
        logic              ready;
        logic              selected;
        logic [1:0]        pace;
    } iopw_state_t;

endpackage

// file: iopw_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes in_data is held stable by the source while in_valid is high.
`timescale 1ns/1ps
module iopw_fifo #(
    parameter  int W     = 8,
    parameter  int DEPTH = 8,
    localparam int PW    = $clog2(DEPTH),
    localparam int CW    = PW + 1
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [CW-1:0]      level
);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } iopw_fifo_st_t;

    iopw_fifo_st_t st;
    iopw_fifo_st_t next_st;
    logic [W-1:0]  slots [0:DEPTH-1];
    logic          push;
    logic          pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("iopw_fifo: DEPTH must be a power of two of at least 2");
    end

    assign in_ready  = st.cnt != CW'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data  = slots[st.rp];
    assign level     = st.cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + PW'(1);
        end
        if (pop) begin
            next_st.rp = st.rp + PW'(1);
        end
        next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            slots[st.wp] <= in_data;
        end
    end

endmodule

// file: iopw_window.sv
// Four-port host window onto one board's paged byte array.
// Assumes host strobes synchronous to ref_clk; the bus wire is resolved outside.
`timescale 1ns/1ps
module iopw_window #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic [7:0]                  port_group_base,
    input  wire logic [iopw_pkg::BOARD_W-1:0] board_number,
    input  wire logic [7:0]                  io_addr,
    input  wire logic                        io_rd,
    input  wire logic                        io_wr,
    input  wire logic [iopw_pkg::DATA_W-1:0] io_wdata,
    output logic                             io_ready,
    output logic [iopw_pkg::DATA_W-1:0]      io_rdata,
    output logic                             io_rdata_oe,
    output logic                             io_rd_valid,
    output logic                             protect_active,
    output logic                             board_selected
);

    localparam int WR_W = $bits(iopw_pkg::iopw_wr_t);
    localparam int LV_W = $clog2(FIFO_DEPTH) + 1;

    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("iopw_window: FIFO_DEPTH must be a power of two of at least 2");
    end

    iopw_pkg::iopw_state_t st;
    iopw_pkg::iopw_state_t next_st;

    logic [iopw_pkg::DATA_W-1:0] mem [0:(2**iopw_pkg::ARR_AW)-1];

    logic               hit;
    logic               sel;
    logic               take_wr;
    logic               take_rd;
    logic               fifo_push;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic               fifo_pop;
    logic [LV_W-1:0]    fifo_level;
    iopw_pkg::iopw_wr_t fifo_in;
    iopw_pkg::iopw_wr_t fifo_out;
    logic [WR_W-1:0]    fifo_out_bits;

    // Group match ignores the two offset bits
    function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
        return addr[7:2] == base[7:2];
    endfunction

    // Board-local array address: bank, page top, page low, byte position
    function automatic logic [iopw_pkg::ARR_AW-1:0] arr_addr(
        input logic [iopw_pkg::HIGH_W-1:0] high,
        input logic [iopw_pkg::LOW_W-1:0]  low,
        input logic [iopw_pkg::POS_W-1:0]  pos
    );
        return {high[iopw_pkg::HI_BANK_MSB:iopw_pkg::HI_PAGE_TOP], low, pos};
    endfunction

    function automatic logic board_match(
        input logic [iopw_pkg::HIGH_W-1:0]  high,
        input logic [iopw_pkg::BOARD_W-1:0] board
    );
        return high[iopw_pkg::HI_BOARD_MSB:iopw_pkg::HI_BOARD_LSB] == board;
    endfunction

    assign hit      = in_group(io_addr, port_group_base);
    assign sel      = board_match(st.high, board_number);
    assign take_wr  = st.ready & io_wr & hit & fifo_in_ready;
    assign take_rd  = st.ready & io_rd & ~io_wr & hit;
    assign fifo_in  = '{addr: arr_addr(st.high, st.low, st.pos), data: io_wdata};
    assign fifo_out = iopw_pkg::iopw_wr_t'(fifo_out_bits);
    // Array accepts one byte per pace period, so bursts back up into the FIFO
    assign fifo_pop = fifo_out_valid & (st.pace == iopw_pkg::PACE_LAST);

    always_comb begin
        next_st          = st;
        next_st.rd_valid = 1'b0;
        next_st.rdata_oe = 1'b0;
        fifo_push        = 1'b0;
        case (st.phase)
            iopw_pkg::IOPW_IDLE: begin
                if (take_wr) begin
                    case (io_addr[1:0])
                        iopw_pkg::OFS_DATA: begin
                            if (sel) begin
                                fifo_push  = ~st.high[iopw_pkg::HI_PROT];
                                next_st.pos = st.pos + iopw_pkg::POS_STEP;
                            end
                        end
                        iopw_pkg::OFS_HIGH: begin
                            next_st.high = io_wdata[iopw_pkg::HIGH_W-1:0];
                        end
                        iopw_pkg::OFS_LOW: begin
                            next_st.low = io_wdata;
                            next_st.pos = iopw_pkg::POS_RST;
                        end
                        default: begin
                            next_st.pos = io_wdata[iopw_pkg::POS_W-1:0];
                        end
                    endcase
                end else if (take_rd && io_addr[1:0] == iopw_pkg::OFS_DATA && sel) begin
                    next_st.rd_addr = arr_addr(st.high, st.low, st.pos);
                    next_st.pos     = st.pos + iopw_pkg::POS_STEP;
                    next_st.phase   = iopw_pkg::IOPW_RD_WAIT;
                end
            end
            iopw_pkg::IOPW_RD_WAIT: begin
                // Let queued writes land before the array is read
                if (!fifo_out_valid) begin
                    next_st.phase = iopw_pkg::IOPW_RD_MEM;
                end
            end
            iopw_pkg::IOPW_RD_MEM: begin
                next_st.rdata    = mem[st.rd_addr];
                next_st.rdata_oe = 1'b1;
                next_st.rd_valid = 1'b1;
                next_st.phase    = iopw_pkg::IOPW_IDLE;
            end
            default: begin
                next_st.phase = iopw_pkg::IOPW_IDLE;
            end
        endcase
        next_st.pace     = (st.pace == iopw_pkg::PACE_LAST) ? 2'h0 : st.pace + iopw_pkg::PACE_STEP;
        next_st.ready    = (next_st.phase == iopw_pkg::IOPW_IDLE)
                           && (int'(fifo_level) + int'(fifo_push) < FIFO_DEPTH);
        next_st.selected = board_match(next_st.high, board_number);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st          <= '0;
            st.phase    <= iopw_pkg::IOPW_IDLE;
            st.high     <= iopw_pkg::HIGH_RST;
            st.low      <= iopw_pkg::LOW_RST;
            st.pos      <= iopw_pkg::POS_RST;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (fifo_pop) begin
            mem[fifo_out.addr] <= fifo_out.data;
        end
    end

    iopw_fifo #(
        .W     (WR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (WR_W'(fifo_in)),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_bits),
        .level     (fifo_level)
    );

    assign io_ready       = st.ready;
    assign io_rdata       = st.rdata;
    assign io_rdata_oe    = st.rdata_oe;
    assign io_rd_valid    = st.rd_valid;
    assign protect_active = st.high[iopw_pkg::HI_PROT];
    assign board_selected = st.selected;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic take_data;
    assign take_data = (take_wr | take_rd) & (io_addr[1:0] == iopw_pkg::OFS_DATA) & sel;

    a_group_decode: assert property (
        st.ready && io_wr && !hit |=> st.high == $past(st.high) && st.low == $past(st.low)
                                      && st.pos == $past(st.pos))
        else $error("write outside the port group changed a register");

    a_data_step: assert property (
        take_data |=> st.pos == iopw_pkg::POS_W'($past(st.pos) + iopw_pkg::POS_STEP))
        else $error("data access did not advance byte position");

    a_page_wrap: assert property (
        take_data && st.pos == 7'h7f |=> st.pos == 7'h00)
        else $error("byte position did not wrap to zero");

    a_high_store: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_HIGH |=> st.high == $past(io_wdata[6:0]))
        else $error("high address register not stored");

    a_protect_flag: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_HIGH |=> protect_active == $past(io_wdata[6]))
        else $error("protect mode does not follow bit six");

    a_low_clears: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_LOW |=> st.pos == 7'h00 && st.low == $past(io_wdata))
        else $error("low page write did not clear byte position");

    a_pos_store: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_POS |=> st.pos == $past(io_wdata[6:0]))
        else $error("byte position register not stored");

    a_reg_read_quiet: assert property (
        st.ready && io_rd && !io_wr && hit && io_addr[1:0] != iopw_pkg::OFS_DATA
        |=> !io_rdata_oe [*3])
        else $error("address register read drove the bus");

    a_other_board: assert property (
        take_rd && !sel |=> !io_rdata_oe && !io_rd_valid [*3])
        else $error("unselected board answered a data read");

    a_protect_hold: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_DATA && protect_active
        |=> fifo_level <= $past(fifo_level))
        else $error("protected write reached the array queue");

    a_read_answer: assert property (
        take_rd && io_addr[1:0] == iopw_pkg::OFS_DATA && sel |-> ##[3:24] (io_rd_valid && io_rdata_oe))
        else $error("data read not answered in time");

    // Register side effects
    a_board_flag: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_HIGH |=> board_selected == ($past(io_wdata[5:3]) == board_number))
        else $error("board flag does not follow bits five to three");

    a_high_keep: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_HIGH
        |=> st.low == $past(st.low) && st.pos == $past(st.pos))
        else $error("high register write disturbed page or position");

    a_low_keep: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_LOW |=> st.high == $past(st.high))
        else $error("low page write disturbed the high register");

    a_pos_keep: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_POS |=> st.low == $past(st.low) && st.high == $past(st.high))
        else $error("position write disturbed the page registers");

    a_reg_read_pos: assert property (
        st.ready && io_rd && !io_wr && hit && io_addr[1:0] != iopw_pkg::OFS_DATA
        |=> st.pos == $past(st.pos) && st.low == $past(st.low) && st.high == $past(st.high))
        else $error("address register read changed a register");

    a_wrap_page: assert property (
        take_data && st.pos == 7'h7f |=> st.low == $past(st.low) && st.high == $past(st.high))
        else $error("byte position wrap left the page");

    a_group_read: assert property (
        st.ready && io_rd && !io_wr && !hit |=> io_ready && !io_rdata_oe)
        else $error("read outside the port group was served");

    a_unsel_pos: assert property (
        (take_wr || take_rd) && io_addr[1:0] == iopw_pkg::OFS_DATA && !sel |=> st.pos == $past(st.pos))
        else $error("unselected board advanced its byte position");

    a_unsel_push: assert property (
        take_wr && io_addr[1:0] == iopw_pkg::OFS_DATA && !sel |-> !fifo_push)
        else $error("unselected board queued a data write");

    a_unsel_ready: assert property (
        take_rd && io_addr[1:0] == iopw_pkg::OFS_DATA && !sel |=> io_ready)
        else $error("unselected board stalled on a data read");

    // Address composition
    a_push_addr: assert property (
        fifo_push |-> fifo_in.addr[6:0] == st.pos && fifo_in.addr[14:7] == st.low
                      && fifo_in.addr[15] == st.high[0] && fifo_in.addr[17:16] == st.high[2:1])
        else $error("queued write address fields misplaced");

    a_rd_addr: assert property (
        take_rd && io_addr[1:0] == iopw_pkg::OFS_DATA && sel
        |=> st.rd_addr[6:0] == $past(st.pos) && st.rd_addr[14:7] == $past(st.low)
            && st.rd_addr[17:15] == $past(st.high[2:0]))
        else $error("read address fields misplaced");

    // Read answer and write queue
    a_ready_read: assert property (
        take_rd && io_addr[1:0] == iopw_pkg::OFS_DATA && sel |=> !io_ready)
        else $error("ready stayed high during a data read");

    a_wr_no_answer: assert property (
        take_wr |=> !io_rd_valid)
        else $error("write produced a read answer");

    a_oe_valid: assert property (
        io_rdata_oe == io_rd_valid)
        else $error("bus drive and read valid disagree");

    a_oe_pulse: assert property (
        io_rdata_oe |=> !io_rdata_oe)
        else $error("bus driven for more than one cycle");

    a_rdata_hold: assert property (
        !io_rd_valid |-> $stable(io_rdata))
        else $error("read data changed without an answer");

    a_ready_back: assert property (
        io_rd_valid |-> io_ready)
        else $error("ready not back in the answer cycle");

    a_read_order: assert property (
        io_rd_valid |-> fifo_level == '0)
        else $error("read answered with writes still queued");

    a_ready_room: assert property (
        io_ready |-> fifo_in_ready)
        else $error("ready offered with a full write queue");

    a_drain_pace: assert property (
        fifo_pop |=> !fifo_pop)
        else $error("array written on two cycles in a row");

    c_data_write: cover property (take_wr && io_addr[1:0] == iopw_pkg::OFS_DATA && sel);
    c_data_read: cover property (io_rd_valid);
    c_fifo_full: cover property (!fifo_in_ready);
    c_wrap: cover property (take_data && st.pos == 7'h7f);
    c_protect_drop: cover property (take_wr && io_addr[1:0] == iopw_pkg::OFS_DATA && sel && protect_active);

endmodule

// file: iopw_host_model.sv
// Host processor model issuing I/O port reads and writes to the window.
// Assumes strobes are taken on a rising edge of ref_clk while io_ready is high.
`timescale 1ns/1ps
module iopw_host_model (
    input  wire logic                        ref_clk,
    input  wire logic                        io_ready,
    input  wire logic [iopw_pkg::DATA_W-1:0] io_rdata,
    input  wire logic                        io_rdata_oe,
    input  wire logic                        io_rd_valid,
    output logic [7:0]                       io_addr,
    output logic                             io_rd,
    output logic                             io_wr,
    output logic [iopw_pkg::DATA_W-1:0]      io_wdata,
    output logic [iopw_pkg::DATA_W-1:0]      host_bus
);
    logic [iopw_pkg::DATA_W-1:0] last;
    int                          stalls;

    // Undriven bus shows the inverse of its last value
    assign host_bus = io_rdata_oe ? io_rdata : ~last;
    always @(posedge ref_clk) last <= host_bus;

    initial begin
        io_addr  = 8'h00;
        io_rd    = 1'b0;
        io_wr    = 1'b0;
        io_wdata = 8'h00;
        stalls   = 0;
    end

    // Output burst: strobe held, next byte only after each take
    task automatic put(input logic [7:0] addr, input logic [7:0] d[$]);
        @(posedge ref_clk);
        #1;
        io_addr = addr;
        io_wr   = 1'b1;
        foreach (d[i]) begin
            io_wdata = d[i];
            while (io_ready !== 1'b1) begin
                stalls++;
                @(posedge ref_clk);
                #1;
            end
            @(posedge ref_clk);
            #1;
        end
        io_wr = 1'b0;
    endtask

    // Input access; got stays low when nobody answers
    task automatic get(input logic [7:0] addr, output logic got, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        got     = 1'b0;
        d       = 8'h00;
        io_addr = addr;
        io_rd   = 1'b1;
        while (io_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        io_rd = 1'b0;
        for (int i = 0; i < 30 && !got; i++) begin
            if (io_rd_valid === 1'b1) begin
                got = 1'b1;
                d   = host_bus;
            end else begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask
endmodule

// file: io_port_paged_memory_window_test.sv
// Self-checking testbench of the paged memory window.
// Assumes the host model drives all strobes; base and board number are static.
`timescale 1ns/1ps
module io_port_paged_memory_window_test;
    localparam logic [7:0] BASE  = 8'hd3;
    localparam logic [2:0] BOARD = 3'h5;
    logic       ref_clk;
    logic       rst;
    logic [7:0] io_addr;
    logic       io_rd;
    logic       io_wr;
    logic [7:0] io_wdata;
    logic       io_ready;
    logic [7:0] io_rdata;
    logic       io_rdata_oe;
    logic       io_rd_valid;
    logic       protect_active;
    logic       board_selected;
    logic [7:0] host_bus;
    int         err_count;
    int         compares;
    logic       got;
    logic [7:0] d;

    iopw_window #(.FIFO_DEPTH(8)) uut (
        .ref_clk(ref_clk), .rst(rst), .port_group_base(BASE), .board_number(BOARD),
        .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_ready(io_ready), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .io_rd_valid(io_rd_valid), .protect_active(protect_active), .board_selected(board_selected));
    iopw_host_model host (
        .ref_clk(ref_clk), .io_ready(io_ready), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .io_rd_valid(io_rd_valid), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .host_bus(host_bus));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] pa(input logic [1:0] o);
        return {BASE[7:2], o};
    endfunction
    function automatic logic [7:0] hi(input logic p, input logic [2:0] b, input logic [2:0] lo);
        return {1'b0, p, b, lo};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] o, input logic [7:0] v);
        host.put(pa(o), '{v});
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(input logic [1:0] o, input logic ans, input logic [7:0] exp);
        host.get(pa(o), got, d);
        chk("answer", {7'h00, ans}, {7'h00, got});
        if (ans)
            chk("read data", exp, d);
    endtask

    task automatic t_high();
        wr(2'h1, 8'hff);
        chk("protect on", 8'h01, {7'h00, protect_active});
        chk("board off", 8'h00, {7'h00, board_selected});
        wr(2'h1, 8'h80 | hi(1'b0, BOARD, 3'h3));
        chk("protect off", 8'h00, {7'h00, protect_active});
        chk("board on", 8'h01, {7'h00, board_selected});
        $display("test high register done");
    endtask

    task automatic t_data();
        wr(2'h2, 8'h40);
        host.put(pa(2'h0), '{8'h11, 8'h22, 8'h33});
        wr(2'h2, 8'h40);
        rd(2'h0, 1'b1, 8'h11);
        rd(2'h0, 1'b1, 8'h22);
        rd(2'h0, 1'b1, 8'h33);
        wr(2'h3, 8'h81);
        rd(2'h0, 1'b1, 8'h22);
        wr(2'h2, 8'h42);
        wr(2'h3, 8'h7f);
        host.put(pa(2'h0), '{8'haa, 8'hbb});
        wr(2'h3, 8'h7f);
        rd(2'h0, 1'b1, 8'haa);
        rd(2'h0, 1'b1, 8'hbb);
        wr(2'h2, 8'h42);
        rd(2'h0, 1'b1, 8'hbb);
        $display("test data port done");
    endtask

    task automatic t_alias();
        wr(2'h1, hi(1'b0, BOARD, 3'h1));
        wr(2'h2, 8'h40);
        host.put(pa(2'h0), '{8'h5a});
        wr(2'h1, hi(1'b0, BOARD, 3'h2));
        wr(2'h2, 8'h40);
        host.put(pa(2'h0), '{8'hc3});
        wr(2'h1, hi(1'b0, BOARD, 3'h3));
        wr(2'h2, 8'h40);
        rd(2'h0, 1'b1, 8'h11);
        wr(2'h1, hi(1'b0, BOARD, 3'h1));
        wr(2'h2, 8'h40);
        rd(2'h0, 1'b1, 8'h5a);
        $display("test bank and page bits done");
    endtask

    task automatic t_protect();
        wr(2'h1, hi(1'b1, BOARD, 3'h3));
        wr(2'h3, 8'h00);
        host.put(pa(2'h0), '{8'hee, 8'hee});
        wr(2'h1, hi(1'b0, BOARD, 3'h3));
        rd(2'h0, 1'b1, 8'h33);
        wr(2'h3, 8'h00);
        rd(2'h0, 1'b1, 8'h11);
        $display("test write protect done");
    endtask

    task automatic t_unsel();
        wr(2'h1, hi(1'b0, 3'h2, 3'h3));
        wr(2'h2, 8'h40);
        chk("board off", 8'h00, {7'h00, board_selected});
        host.put(pa(2'h0), '{8'h77});
        rd(2'h0, 1'b0, 8'h00);
        host.put({BASE[7:2] ^ 6'h01, 2'h2}, '{8'h00});
        wr(2'h1, hi(1'b0, BOARD, 3'h3));
        rd(2'h1, 1'b0, 8'h00);
        rd(2'h2, 1'b0, 8'h00);
        rd(2'h3, 1'b0, 8'h00);
        rd(2'h0, 1'b1, 8'h11);
        $display("test unselected board done");
    endtask

    task automatic t_burst();
        logic [7:0] q[$];
        for (int i = 0; i < 20; i++)
            q.push_back(8'(i * 3 + 1));
        wr(2'h2, 8'h41);
        host.stalls = 0;
        host.put(pa(2'h0), q);
        chk("stalled", 8'h01, {7'h00, host.stalls > 0});
        wr(2'h2, 8'h41);
        foreach (q[i])
            rd(2'h0, 1'b1, q[i]);
        $display("test write burst done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200us;
        err_count++;
        print_verdict();
    end

    initial begin
        err_count = 0;
        compares  = 0;
        rst       = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1;
        chk("ready in reset", 8'h00, {7'h00, io_ready});
        chk("protect in reset", 8'h00, {7'h00, protect_active});
        rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("board after reset", 8'h00, {7'h00, board_selected});
        t_high();
        t_data();
        t_alias();
        t_protect();
        t_unsel();
        t_burst();
        print_verdict();
    end
endmodule
